/* hdl/fdc_consts.vh */
// Constants for the shift-register pointer DRAM FIFO controller.
`ifndef FDC_CONSTS_VH
`define FDC_CONSTS_VH
`define FDC_PTR_W 20
`define FDC_ADDR_W 10
`define FDC_TAP_HI 19
`define FDC_TAP_LO 16
`define FDC_PTR_RST 20'h00000
`define FDC_CLK_NS 4
`define FDC_PHASE_NS 60
`define FDC_PHASE_CYC ((`FDC_PHASE_NS + `FDC_CLK_NS - 1) / `FDC_CLK_NS)
`define FDC_REF_NS 15600
`define FDC_REF_CYC (`FDC_REF_NS / `FDC_CLK_NS)
`define FDC_CNT_W 12
`endif

/* hdl/fdc_lfsr_ptr.v */
// Twenty-bit shift-register pointer with XNOR feedback, used for both FIFO pointers.
`timescale 1ns/1ns
`include "fdc_consts.vh"
module fdc_lfsr_ptr (
  input wire mclk,
  input wire rst_n,
  input wire step,
  output reg [`FDC_PTR_W-1:0] ptr_r,
  output wire [`FDC_PTR_W-1:0] ptr_nxt
);
  // XNOR feedback makes all-ones the lockup state, so reset to zero is safe.
  assign ptr_nxt = {ptr_r[`FDC_PTR_W-2:0], ~(ptr_r[`FDC_TAP_HI] ^ ptr_r[`FDC_TAP_LO])};

  // The pointer moves only when its access has finished.
  always @(posedge mclk) begin
    if (!rst_n) begin
      ptr_r <= `FDC_PTR_RST;
    end else if (step) begin
      ptr_r <= ptr_nxt;
    end
  end
endmodule

/* hdl/fdc_ctrl.v */
// Bit-serial FIFO controller that stores its data in a single-port DRAM.
// What this block does
// - A 20-bit write pointer selects the DRAM location for the next incoming bit.
// - A separate 20-bit read pointer selects the DRAM location of the next bit to deliver.
// - A write that leaves the pointers equal sets full, and writes are refused while full.
// - A read that leaves the pointers equal sets empty, and reads are refused while empty.
// - DRAM reads and writes run strictly one after another, so the last operation tells full from empty.
// - Both pointers are shift-register counters with identical feedback and so the same sequence.
// - Each pointer has a period of two to the twentieth minus one, skipping one lockup state.
// - The 10-bit DRAM address is taken from alternate pointer bits with no separate selector.
// - Those bits give the row address before the increment shift and the column address after it.
// - User requests arrive at any time and are synchronised before any DRAM cycle starts.
// - Refresh drives the column strobe before the row strobe and supplies no address.
`timescale 1ns/1ns
`include "fdc_consts.vh"
module fdc_ctrl (
  input wire mclk,
  input wire rst_n,
  input wire wr_req,
  input wire wr_data,
  input wire rd_req,
  output reg wr_done_r,
  output reg rd_valid_r,
  output reg rd_data_r,
  output reg full_r,
  output reg empty_r,
  output reg [`FDC_ADDR_W-1:0] dram_addr_r,
  output reg dram_ras_n_r,
  output reg dram_cas_n_r,
  output reg dram_we_n_r,
  output reg dram_din_r,
  input wire dram_dout
);
  localparam [31:0] PH_LOAD_I = `FDC_PHASE_CYC - 1;
  localparam [31:0] REF_LOAD_I = `FDC_REF_CYC - 1;
  // The counts are cut to the counter width on purpose; both fit well inside it.
  localparam [`FDC_CNT_W-1:0] PH_LOAD = PH_LOAD_I[`FDC_CNT_W-1:0];
  localparam [`FDC_CNT_W-1:0] REF_LOAD = REF_LOAD_I[`FDC_CNT_W-1:0];
  localparam [5:0] S_IDLE = 6'h01;
  localparam [5:0] S_ROW = 6'h02;
  localparam [5:0] S_COL = 6'h04;
  localparam [5:0] S_PRE = 6'h08;
  localparam [5:0] S_RCAS = 6'h10;
  localparam [5:0] S_RRAS = 6'h20;

  reg [5:0] state_r;
  reg op_wr_r;
  reg last_wr_r;
  reg [2:0] wr_sync_r;
  reg [2:0] rd_sync_r;
  reg wr_pend_r;
  reg rd_pend_r;
  reg ref_pend_r;
  reg wr_buf_r;
  reg [`FDC_CNT_W-1:0] ph_cnt_r;
  reg [`FDC_CNT_W-1:0] ref_cnt_r;
  wire [`FDC_PTR_W-1:0] wptr;
  wire [`FDC_PTR_W-1:0] wptr_nxt;
  wire [`FDC_PTR_W-1:0] rptr;
  wire [`FDC_PTR_W-1:0] rptr_nxt;
  wire wr_edge;
  wire rd_edge;
  wire ph_done;
  wire ref_due;
  wire wr_ok;
  wire rd_ok;
  reg grant_ref;
  reg grant_wr;
  reg grant_rd;
  reg wr_take;
  reg rd_take;
  wire col_end;
  wire wstep;
  wire rstep;

  // Alternate pointer bits form the DRAM address, so no row/column selector is needed.
  function [`FDC_ADDR_W-1:0] fdc_alt_bits;
    input [`FDC_PTR_W-1:0] p;
    integer i;
    begin
      for (i = 0; i < `FDC_ADDR_W; i = i + 1) begin
        fdc_alt_bits[i] = p[2*i];
      end
    end
  endfunction

  // Both pointers share one module, hence identical feedback and sequence.
  fdc_lfsr_ptr u_wptr (
    .mclk(mclk),
    .rst_n(rst_n),
    .step(wstep),
    .ptr_r(wptr),
    .ptr_nxt(wptr_nxt)
  );

  fdc_lfsr_ptr u_rptr (
    .mclk(mclk),
    .rst_n(rst_n),
    .step(rstep),
    .ptr_r(rptr),
    .ptr_nxt(rptr_nxt)
  );

  // Edge detectors read the second and third stages, never the first.
  assign wr_edge = wr_sync_r[1] & ~wr_sync_r[2];
  assign rd_edge = rd_sync_r[1] & ~rd_sync_r[2];
  assign ph_done = (ph_cnt_r == {`FDC_CNT_W{1'b0}});
  assign ref_due = (ref_cnt_r == {`FDC_CNT_W{1'b0}});
  assign wr_ok = wr_pend_r & ~full_r;
  assign rd_ok = rd_pend_r & ~empty_r;
  assign col_end = state_r[2] & ph_done;
  assign wstep = col_end & op_wr_r;
  assign rstep = col_end & ~op_wr_r;

  // Refresh outranks data; data requests alternate when both wait, so none starves.
  always @* begin
    grant_ref = 1'b0;
    grant_wr = 1'b0;
    grant_rd = 1'b0;
    if (state_r == S_IDLE) begin
      if (ref_pend_r) begin
        grant_ref = 1'b1;
      end else if (wr_ok && (!rd_ok || !last_wr_r)) begin
        grant_wr = 1'b1;
      end else if (rd_ok) begin
        grant_rd = 1'b1;
      end
    end
    // A request is consumed when granted, or dropped when refused in idle.
    wr_take = grant_wr | ((state_r == S_IDLE) & wr_pend_r & full_r);
    rd_take = grant_rd | ((state_r == S_IDLE) & rd_pend_r & empty_r);
  end

  // Synchronisers, pending flags and the refresh timer; a new event beats a take.
  always @(posedge mclk) begin
    if (!rst_n) begin
      wr_sync_r <= 3'h0;
      rd_sync_r <= 3'h0;
      wr_pend_r <= 1'b0;
      rd_pend_r <= 1'b0;
      ref_pend_r <= 1'b0;
      wr_buf_r <= 1'b0;
      ref_cnt_r <= REF_LOAD;
    end else begin
      wr_sync_r <= {wr_sync_r[1:0], wr_req};
      rd_sync_r <= {rd_sync_r[1:0], rd_req};
      wr_pend_r <= wr_edge | (wr_pend_r & ~wr_take);
      rd_pend_r <= rd_edge | (rd_pend_r & ~rd_take);
      // Data is caught with the synchronised edge; the user must hold it for three clocks after the request rises.
      if (wr_edge) begin
        wr_buf_r <= wr_data;
      end
      ref_pend_r <= ref_due | (ref_pend_r & ~grant_ref);
      ref_cnt_r <= ref_due ? REF_LOAD : ref_cnt_r - 1'b1;
    end
  end

  // Cycle sequencer: one DRAM access at a time, each phase held a fixed time.
  always @(posedge mclk) begin
    if (!rst_n) begin
      state_r <= S_IDLE;
      op_wr_r <= 1'b0;
      last_wr_r <= 1'b0;
      ph_cnt_r <= {`FDC_CNT_W{1'b0}};
      wr_done_r <= 1'b0;
      rd_valid_r <= 1'b0;
      rd_data_r <= 1'b0;
      full_r <= 1'b0;
      empty_r <= 1'b1;
      dram_addr_r <= {`FDC_ADDR_W{1'b0}};
      dram_ras_n_r <= 1'b1;
      dram_cas_n_r <= 1'b1;
      dram_we_n_r <= 1'b1;
      dram_din_r <= 1'b0;
    end else begin
      wr_done_r <= 1'b0;
      rd_valid_r <= 1'b0;
      if (!ph_done) begin
        ph_cnt_r <= ph_cnt_r - 1'b1;
      end
      case (state_r)
        S_IDLE: begin
          if (grant_ref) begin
            state_r <= S_RCAS;
            dram_cas_n_r <= 1'b0;
            ph_cnt_r <= PH_LOAD;
          end else if (grant_wr || grant_rd) begin
            state_r <= S_ROW;
            op_wr_r <= grant_wr;
            last_wr_r <= grant_wr;
            dram_addr_r <= fdc_alt_bits(grant_wr ? wptr : rptr);
            dram_din_r <= wr_buf_r;
            dram_ras_n_r <= 1'b0;
            ph_cnt_r <= PH_LOAD;
          end
        end
        S_ROW: begin
          if (ph_done) begin
            state_r <= S_COL;
            dram_addr_r <= fdc_alt_bits(op_wr_r ? wptr_nxt : rptr_nxt);
            dram_cas_n_r <= 1'b0;
            dram_we_n_r <= ~op_wr_r;
            ph_cnt_r <= PH_LOAD;
          end
        end
        S_COL: begin
          if (ph_done) begin
            state_r <= S_PRE;
            dram_ras_n_r <= 1'b1;
            dram_cas_n_r <= 1'b1;
            dram_we_n_r <= 1'b1;
            ph_cnt_r <= PH_LOAD;
            // Flags come from the operation just finished; accesses never overlap.
            if (op_wr_r) begin
              wr_done_r <= 1'b1;
              full_r <= (wptr_nxt == rptr);
              empty_r <= 1'b0;
            end else begin
              rd_data_r <= dram_dout;
              rd_valid_r <= 1'b1;
              empty_r <= (rptr_nxt == wptr);
              full_r <= 1'b0;
            end
          end
        end
        S_RCAS: begin
          if (ph_done) begin
            state_r <= S_RRAS;
            dram_ras_n_r <= 1'b0;
            ph_cnt_r <= PH_LOAD;
          end
        end
        S_RRAS: begin
          if (ph_done) begin
            state_r <= S_PRE;
            dram_ras_n_r <= 1'b1;
            dram_cas_n_r <= 1'b1;
            ph_cnt_r <= PH_LOAD;
          end
        end
        S_PRE: begin
          // Precharge time lets the row strobe recover before the next access.
          if (ph_done) begin
            state_r <= S_IDLE;
          end
        end
        default: begin
          state_r <= S_IDLE;
        end
      endcase
    end
  end
endmodule

/* dv/fdc_monitor.sv */
// Port checker for the DRAM FIFO controller.
`timescale 1ns/1ns
module fdc_monitor (
  input wire mclk,
  input wire rst_n,
  input wire wr_done_r,
  input wire rd_valid_r,
  input wire full_r,
  input wire empty_r,
  input wire [9:0] dram_addr_r,
  input wire dram_ras_n_r,
  input wire dram_cas_n_r,
  input wire dram_we_n_r
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n);
  // Accesses finish one at a time, and each flag rises only with its own kind of access.
  one_access_a: assert property (!(wr_done_r && rd_valid_r)) else $error("two ends");
  full_by_wr_a: assert property ($rose(full_r) |-> wr_done_r) else $error("full");
  empty_by_rd_a: assert property ($rose(empty_r) |-> rd_valid_r) else $error("empty");
  // Refresh drops the column strobe first; an access drops the row strobe first.
  refresh_cbr_a: assert property ($fell(dram_cas_n_r) && dram_ras_n_r
    |-> dram_we_n_r ##15 $fell(dram_ras_n_r)) else $error("refresh");
  row_col_a: assert property ($fell(dram_ras_n_r) && dram_cas_n_r
    |-> ##15 $fell(dram_cas_n_r)) else $error("column");
  row_hold_a: assert property ($fell(dram_ras_n_r) && dram_cas_n_r
    |=> $stable(dram_addr_r) [*8]) else $error("row");
  // A pulse may only follow the strobes of its own access.
  wr_end_a: assert property (wr_done_r |-> !$past(dram_we_n_r)) else $error("wr");
  rd_end_a: assert property (rd_valid_r
    |-> !$past(dram_cas_n_r) && $past(dram_we_n_r)) else $error("rd");
endmodule
bind fdc_ctrl fdc_monitor u_mon (.mclk(mclk), .rst_n(rst_n), .wr_done_r(wr_done_r),
  .rd_valid_r(rd_valid_r), .full_r(full_r), .empty_r(empty_r), .dram_addr_r(dram_addr_r),
  .dram_ras_n_r(dram_ras_n_r), .dram_cas_n_r(dram_cas_n_r), .dram_we_n_r(dram_we_n_r));

/* dv/fdc_dram_model.sv */
// Behavioural single-port DRAM holding one bit per row and column pair.
`timescale 1ns/1ns
module fdc_dram_model (
  input wire mclk,
  input wire [9:0] addr,
  input wire ras_n,
  input wire cas_n,
  input wire we_n,
  input wire din,
  output wire dout
);
  // A plain array keeps the model within what every simulator accepts.
  reg mem [0:1048575];
  reg [9:0] row = 10'h000;
  reg [19:0] key = 20'h00000;
  reg ras_q = 1'b1, cas_q = 1'b1, last = 1'b0, rbit = 1'b0;
  // Edges are found on sampled strobes so that address and strobe never race.
  always @(posedge mclk) begin
    ras_q <= ras_n;
    cas_q <= cas_n;
    last <= dout;
    if (ras_q && !ras_n && cas_n) row <= addr;
    if (cas_q && !cas_n && !ras_n) begin
      key <= {row, addr};
      rbit <= mem[{row, addr}];
      if (!we_n) mem[{row, addr}] <= din;
    end
  end
  // Outside a read the line toggles, so a stale bit never passes for data.
  assign dout = (!ras_n && !cas_n && we_n) ? rbit : ~last;
endmodule

/* dv/fdc_tb.sv */
// Self-checking bench for the DRAM FIFO controller.
`timescale 1ns/1ns
`define CHK(nm, e, g) begin comparisons++; if ((g) !== (e)) begin n_mismatch++; \
  $display("unexpected %s exp %h got %h", nm, e, g); end end
module tb;
  reg mclk = 1'b0, rst_n = 1'b0, wr_req = 1'b0, wr_data = 1'b0, rd_req = 1'b0;
  wire wr_done_r, rd_valid_r, rd_data_r, full_r, empty_r, ras_n, cas_n, we_n, din, dout;
  wire [9:0] addr;
  int comparisons = 0, n_mismatch = 0;
  reg [19:0] wp = 20'h00000, rp = 20'h00000;
  logic q, ok;
  localparam [3:0] PAT = 4'hB;
  fdc_ctrl u_dut (.mclk(mclk), .rst_n(rst_n), .wr_req(wr_req), .wr_data(wr_data),
    .rd_req(rd_req), .wr_done_r(wr_done_r), .rd_valid_r(rd_valid_r), .rd_data_r(rd_data_r),
    .full_r(full_r), .empty_r(empty_r), .dram_addr_r(addr), .dram_ras_n_r(ras_n),
    .dram_cas_n_r(cas_n), .dram_we_n_r(we_n), .dram_din_r(din), .dram_dout(dout));
  fdc_dram_model u_mem (.mclk(mclk), .addr(addr), .ras_n(ras_n), .cas_n(cas_n),
    .we_n(we_n), .din(din), .dout(dout));
  initial forever #2 mclk = ~mclk;
  function automatic [19:0] nx(input [19:0] p);
    nx = {p[18:0], ~(p[19] ^ p[16])};
  endfunction
  function automatic [9:0] ev(input [19:0] p);
    for (int i = 0; i < 10; i++) ev[i] = p[2 * i];
  endfunction
  // One request held until its pulse; the DRAM cell it used must match the pointer.
  task automatic xfer(input bit w, input bit d, input bit exp_ok);
    int n;
    n = 0;
    ok = 1'b0;
    @(posedge mclk);
    wr_data <= d;
    if (w) wr_req <= 1'b1;
    else rd_req <= 1'b1;
    while (ok !== 1'b1 && n < 200) begin
      @(posedge mclk);
      #1 ok = w ? wr_done_r : rd_valid_r;
      n++;
    end
    `CHK("done", exp_ok, ok)
    if (exp_ok) begin
      `CHK("cell", w ? {ev(wp), ev(nx(wp))} : {ev(rp), ev(nx(rp))}, u_mem.key)
      if (w) wp = nx(wp);
      else rp = nx(rp);
    end
    q = rd_data_r;
    @(posedge mclk);
    wr_req <= 1'b0;
    rd_req <= 1'b0;
    repeat (6) @(posedge mclk);
  endtask
  // Reading an empty store is refused; full cannot be reached in a short run.
  task automatic t_idle;
    `CHK("empty", 1'b1, empty_r)
    `CHK("full", 1'b0, full_r)
    `CHK("strobes", 3'h7, {ras_n, cas_n, we_n})
    xfer(0, 0, 0);
  endtask
  task automatic t_write;
    for (int i = 0; i < 4; i++) xfer(1, PAT[i], 1);
    `CHK("empty", 1'b0, empty_r)
  endtask
  task automatic t_refresh;
    int n;
    logic cp;
    n = 0;
    cp = 1'b1;
    repeat (8000) begin
      @(posedge mclk);
      #1 if (cas_n === 1'b0 && cp === 1'b1 && ras_n === 1'b1) n++;
      cp = cas_n;
    end
    `CHK("refresh", 1'b1, n >= 2)
  endtask
  task automatic t_read;
    for (int i = 0; i < 4; i++) begin
      xfer(0, 0, 1);
      `CHK("data", PAT[i], q)
    end
    `CHK("empty", 1'b1, empty_r)
    xfer(0, 0, 0);
  endtask
  // Write and read rise together after a write: the read is served first, then the write.
  task automatic t_both;
    int n;
    int t_rd;
    int t_wr;
    xfer(1, 1'b0, 1);
    n = 0;
    t_rd = 0;
    t_wr = 0;
    @(posedge mclk);
    wr_data <= 1'b1;
    wr_req <= 1'b1;
    rd_req <= 1'b1;
    while ((t_rd == 0 || t_wr == 0) && n < 300) begin
      @(posedge mclk);
      #1 n++;
      if (rd_valid_r === 1'b1) begin
        t_rd = n;
        q = rd_data_r;
      end
      if (wr_done_r === 1'b1) t_wr = n;
    end
    `CHK("data", 1'b0, q)
    `CHK("order", 1'b1, t_rd > 0 && t_wr > t_rd)
    rp = nx(rp);
    wp = nx(wp);
    @(posedge mclk);
    wr_req <= 1'b0;
    rd_req <= 1'b0;
    repeat (6) @(posedge mclk);
    xfer(0, 0, 1);
    `CHK("data", 1'b1, q)
    `CHK("empty", 1'b1, empty_r)
  endtask
  task automatic summarize;
    if (n_mismatch == 0 && comparisons > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  initial begin
    repeat (8) @(posedge mclk);
    rst_n <= 1'b1;
    @(posedge mclk);
    #1 t_idle;
    t_write;
    t_refresh;
    t_read;
    t_both;
    summarize;
  end
  // The tests need about 10000 cycles; this limit leaves twice that.
  initial begin
    #80000;
    n_mismatch++;
    summarize;
  end
endmodule
